/* rtl/sdp_pin_sync.sv */
/*
 * Synchroniser and edge finder for the debug clock and data pins.
 * Assumes both pins are asynchronous to clk and change slower than clk/2.
 */
`timescale 1ns/1ps
module sdp_pin_sync (
    // Clock and reset.
    input  wire logic            clk,
    input  wire logic            rst,
    // Raw pins.
    input  wire logic            dbgClkPin,
    input  wire logic            dbgDataPin,
    // Conditioned view.
    output sdp_pkg::sdp_pins_s   pins
);

    logic [1:0] clkSync_q;
    logic [1:0] dataSync_q;
    logic       clkPrev_q;
    logic       dataPrev_q;

    // two-stage synchronisers.
    // The first stage feeds only the second so metastability cannot reach logic.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            clkSync_q  <= 2'h3;
            dataSync_q <= 2'h3;
        end else begin
            clkSync_q  <= {clkSync_q[0], dbgClkPin};
            dataSync_q <= {dataSync_q[0], dbgDataPin};
        end
    end

    // Previous synchronised levels for edge detection.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            clkPrev_q  <= 1'b1;
            dataPrev_q <= 1'b1;
        end else begin
            clkPrev_q  <= clkSync_q[1];
            dataPrev_q <= dataSync_q[1];
        end
    end

    always_comb begin
        pins.clkLevel  = clkSync_q[1];
        pins.dataLevel = dataSync_q[1];
        pins.clkRise   = clkSync_q[1] & ~clkPrev_q;
        pins.clkFall   = ~clkSync_q[1] & clkPrev_q;
        // start is data falling while clock stays high.
        // a rising data edge under high clock decodes as nothing.
        pins.startSeen = clkSync_q[1] & clkPrev_q & dataPrev_q & ~dataSync_q[1];
    end

endmodule

/* rtl/sdp_pkg.sv */
/*
 * Shared constants and carrier types for the serial debug slave port.
 * Assumes a 100 MHz system clock and a master clocking at most half of it.
 */
package sdp_pkg;

    // Address ceilings for block transfers.
    localparam logic [6:0] SDP_WR_TOP      = 7'h30;
    localparam logic [6:0] SDP_RD_TOP      = 7'h20;
    // Bits in a byte and position of the separator slot.
    localparam logic [3:0] SDP_DATA_BITS   = 4'h8;
    localparam logic [3:0] SDP_SEP_SLOT    = 4'h8;
    // Clock rate and the shortest legal debug clock half period.
    localparam int         SDP_CLK_MHZ     = 100;
    localparam int         SDP_MIN_HALF_NS = 10;
    localparam int         SDP_MIN_HALF_CYC = (SDP_MIN_HALF_NS * SDP_CLK_MHZ + 999) / 1000;

    // Synchronised pin levels and their edges.
    typedef struct packed {
        logic clkRise;
        logic clkFall;
        logic clkLevel;
        logic dataLevel;
        logic startSeen;
    } sdp_pins_s;

    // Register access strobes towards the debug register file.
    typedef struct packed {
        logic       wrStrobe;
        logic       rdStrobe;
        logic [6:0] addr;
        logic [7:0] wrData;
    } sdp_acc_s;

    typedef enum logic [1:0] {
        SDP_IDLE = 2'b00,
        SDP_ADDR = 2'b01,
        SDP_WR   = 2'b10,
        SDP_RD   = 2'b11
    } sdp_state_e;

endpackage

/* rtl/sdp_serial_debug_port.sv */
/*
 * Serial debug slave port: start detection, address phase, byte shifting
 * with separators, block auto-increment and bus grant gating.
 * Assumes an external register file answers reads combinationally from addr
 * and that the master keeps its clock at or below half of clk.
 */
// Overview of operation
// - Master starts every transfer and drives the clock; port is slave.
// - Pins work only while instrumentation is off, enabling the port.
// - Data changes only while debug clock low, except for start.
// - Bytes move bit 7 first, bit 0 last.
// - Each byte takes nine clocks: eight data, one separator.
// - Data falling while clock high starts a command; all else ignored before.
// - Data rising while clock high has no effect.
// - Write bits sampled on debug clock rising edge.
// - Read bits updated on debug clock falling edge.
// - Separators zero mid-command; no bus grant until separator one.
// - Seven address bits, direction bit, separator; 0 write, 1 read.
// - Reads and writes at one address reach distinct registers.
// - Without new start, further bytes repeat the same operation.
// - Single write captures data on the next eight rising edges.
// - Block write increments address, stopping at 30h.
// - Read loads shifter at first debug clock fall after separator, msb first.
// - Block read increments address, stopping at 20h.
// - Registers reachable without disturbing the running machine.
// - Grant only at separator one or when idle; disabled after reset.
`timescale 1ns/1ps
module sdp_serial_debug_port (
    // Clock and reset.
    input  wire logic            clk,
    input  wire logic            rst,
    // Mode and grant control.
    input  wire logic            instrDisable,
    input  wire logic            grantEnable,
    input  wire logic            busRequestIn,
    // Debug pins.
    input  wire logic            dbgClkIn,
    input  wire logic            dbgDataIn,
    output logic                 dbgDataOut,
    output logic                 dbgDataOe,
    // Register file side.
    input  wire logic [7:0]      rdData,
    output sdp_pkg::sdp_acc_s    acc,
    output logic                 busGrantOut
);

    sdp_pkg::sdp_pins_s  pins;
    sdp_pkg::sdp_state_e state_q;
    logic [3:0]          bitCnt_q;
    logic [7:0]          shift_q;
    logic [6:0]          addr_q;
    logic                opActive_q;
    logic                enSync0_q;
    logic                enSync_q;
    logic                reqSync0_q;
    logic                reqSync_q;
    logic                lastSep_q;

    // Raw pins go straight into the synchroniser.
    // The enable is applied after it, because a mux ahead of it could forge edges.
    sdp_pin_sync u_sync (
        .clk        (clk),
        .rst        (rst),
        .dbgClkPin  (dbgClkIn),
        .dbgDataPin (dbgDataIn),
        .pins       (pins)
    );

    // Bus request arrives from a pin, so it is synchronised first.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            reqSync0_q <= 1'b0;
            reqSync_q  <= 1'b0;
            enSync0_q  <= 1'b0;
            enSync_q   <= 1'b0;
        end else begin
            reqSync0_q <= busRequestIn;
            reqSync_q  <= reqSync0_q;
            enSync0_q  <= instrDisable;
            enSync_q   <= enSync0_q;
        end
    end

    // Main sequencer: state, bit count, shift register and address.
    // the port only reacts to master edges and never drives the clock.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_q     <= sdp_pkg::SDP_IDLE;
            bitCnt_q    <= 4'h0;
            shift_q     <= 8'h00;
            addr_q      <= 7'h00;
            opActive_q  <= 1'b0;
            lastSep_q   <= 1'b1;
            acc         <= '0;
        end else begin
            acc.wrStrobe <= 1'b0;
            acc.rdStrobe <= 1'b0;
            if (!enSync_q) begin
                state_q    <= sdp_pkg::SDP_IDLE;
                opActive_q <= 1'b0;
            // a start aborts anything and opens the address phase.
            end else if (pins.startSeen) begin
                state_q    <= sdp_pkg::SDP_ADDR;
                bitCnt_q   <= 4'h0;
                opActive_q <= 1'b1;
            end else if (state_q != sdp_pkg::SDP_IDLE && pins.clkRise) begin
                // slots 0..7 carry data, slot 8 carries the separator.
                if (bitCnt_q == sdp_pkg::SDP_SEP_SLOT) begin
                    bitCnt_q  <= 4'h0;
                    lastSep_q <= pins.dataLevel;
                    // activity ends only on a separator of one or when the port is disabled.
                    opActive_q <= ~pins.dataLevel;
                    if (state_q == sdp_pkg::SDP_ADDR) begin
                        // direction bit selects write or read.
                        addr_q      <= shift_q[7:1];
                        state_q     <= shift_q[0] ? sdp_pkg::SDP_RD : sdp_pkg::SDP_WR;
                        acc.addr    <= shift_q[7:1];
                    end
                end else begin
                    bitCnt_q <= bitCnt_q + 4'h1;
                    if (state_q != sdp_pkg::SDP_RD) begin
                        shift_q <= {shift_q[6:0], pins.dataLevel};
                    end
                    opActive_q <= 1'b1;
                    if (bitCnt_q == sdp_pkg::SDP_DATA_BITS - 4'h1) begin
                        // eighth rise completes a write byte.
                        if (state_q == sdp_pkg::SDP_WR) begin
                            acc.wrStrobe <= 1'b1;
                            acc.wrData   <= {shift_q[6:0], pins.dataLevel};
                            acc.addr     <= addr_q;
                            // step up to the write ceiling.
                            if (addr_q != sdp_pkg::SDP_WR_TOP) begin
                                addr_q <= addr_q + 7'h01;
                            end
                        end
                        if (state_q == sdp_pkg::SDP_RD) begin
                            acc.rdStrobe <= 1'b1;
                            acc.addr     <= addr_q;
                            // step up to the read ceiling.
                            if (addr_q != sdp_pkg::SDP_RD_TOP) begin
                                addr_q <= addr_q + 7'h01;
                            end
                        end
                    end
                end
            end else if (state_q == sdp_pkg::SDP_RD && pins.clkFall) begin
                // load on the first fall after a separator, then shift.
                // outgoing bit changes on the fall, msb first.
                if (bitCnt_q == 4'h0) begin
                    shift_q <= rdData;
                end else begin
                    shift_q <= {shift_q[6:0], 1'b0};
                end
            end
            if (state_q == sdp_pkg::SDP_RD && !(pins.clkRise && bitCnt_q == sdp_pkg::SDP_SEP_SLOT)) begin
                acc.addr <= addr_q;
            end
        end
    end

    // drive the pin only while read data bits are shifting.
    // drive changes follow clock falls, so data moves while clock is low.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            dbgDataOe  <= 1'b0;
            dbgDataOut <= 1'b1;
        end else if (state_q == sdp_pkg::SDP_RD && pins.clkFall && bitCnt_q != sdp_pkg::SDP_SEP_SLOT) begin
            dbgDataOe  <= 1'b1;
            dbgDataOut <= (bitCnt_q == 4'h0) ? rdData[7] : shift_q[6];
        end else if ((pins.clkFall && bitCnt_q == sdp_pkg::SDP_SEP_SLOT) || state_q != sdp_pkg::SDP_RD) begin
            dbgDataOe  <= 1'b0;
            dbgDataOut <= 1'b1;
        end
    end

    // grant only when enabled and the port is not mid-operation.
    // grant logic never touches the sequencer, so debug access is passive.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            busGrantOut <= 1'b0;
        end else begin
            busGrantOut <= grantEnable & reqSync_q & ~opActive_q & lastSep_q;
        end
    end

    // Assertions.
    sequence s_sepOne;
        state_q != sdp_pkg::SDP_IDLE && pins.clkRise && bitCnt_q == sdp_pkg::SDP_SEP_SLOT && pins.dataLevel;
    endsequence

    property p_grantBlocked;
        @(posedge clk) disable iff (rst)
        opActive_q |=> !busGrantOut;
    endproperty
    a_grantBlocked: assert property (p_grantBlocked) else $error("Grant raised during operation.");

    property p_grantAfterSep;
        @(posedge clk) disable iff (rst)
        s_sepOne ##1 (grantEnable && reqSync_q && !pins.startSeen)[*2] |-> busGrantOut;
    endproperty
    a_grantAfterSep: assert property (p_grantAfterSep) else $error("Grant missing after separator one.");

    property p_noGrantDisabled;
        @(posedge clk) disable iff (rst)
        !grantEnable |=> !busGrantOut;
    endproperty
    a_noGrantDisabled: assert property (p_noGrantDisabled) else $error("Grant while disabled.");

    property p_startAddr;
        @(posedge clk) disable iff (rst)
        (pins.startSeen && enSync_q) |=> (state_q == sdp_pkg::SDP_ADDR && bitCnt_q == 4'h0);
    endproperty
    a_startAddr: assert property (p_startAddr) else $error("Start did not open address phase.");

    property p_oeOnlyRead;
        @(posedge clk) disable iff (rst)
        dbgDataOe |-> $past(state_q) == sdp_pkg::SDP_RD;
    endproperty
    a_oeOnlyRead: assert property (p_oeOnlyRead) else $error("Pin driven outside a read.");

    property p_oeOnFall;
        @(posedge clk) disable iff (rst)
        $rose(dbgDataOe) |-> $past(pins.clkFall);
    endproperty
    a_oeOnFall: assert property (p_oeOnFall) else $error("Drive began off a falling edge.");

    property p_wrCeiling;
        @(posedge clk) disable iff (rst)
        (acc.wrStrobe && acc.addr == sdp_pkg::SDP_WR_TOP) |-> addr_q == sdp_pkg::SDP_WR_TOP;
    endproperty
    a_wrCeiling: assert property (p_wrCeiling) else $error("Write address passed ceiling.");

    property p_rdCeiling;
        @(posedge clk) disable iff (rst)
        (acc.rdStrobe && acc.addr == sdp_pkg::SDP_RD_TOP) |-> addr_q == sdp_pkg::SDP_RD_TOP;
    endproperty
    a_rdCeiling: assert property (p_rdCeiling) else $error("Read address passed ceiling.");

    property p_wrStep;
        @(posedge clk) disable iff (rst)
        (acc.wrStrobe && acc.addr < sdp_pkg::SDP_WR_TOP) |-> addr_q == acc.addr + 7'h01;
    endproperty
    a_wrStep: assert property (p_wrStep) else $error("Write address did not step by one.");

    property p_dirSelect;
        @(posedge clk) disable iff (rst)
        (state_q == sdp_pkg::SDP_ADDR && pins.clkRise && bitCnt_q == sdp_pkg::SDP_SEP_SLOT && !pins.startSeen
         && enSync_q) |=> state_q == ($past(shift_q[0]) ? sdp_pkg::SDP_RD : sdp_pkg::SDP_WR);
    endproperty
    a_dirSelect: assert property (p_dirSelect) else $error("Direction decode wrong.");

    property p_writeRising;
        @(posedge clk) disable iff (rst)
        acc.wrStrobe |-> $past(pins.clkRise);
    endproperty
    a_writeRising: assert property (p_writeRising) else $error("Write byte not taken on rising edge.");

    // A separator rise that neither a start nor a disable overrides.
    sequence s_sepRise;
        state_q != sdp_pkg::SDP_IDLE && pins.clkRise && bitCnt_q == sdp_pkg::SDP_SEP_SLOT
        && enSync_q && !pins.startSeen;
    endsequence

    property p_sepClears;
        @(posedge clk) disable iff (rst)
        s_sepRise |=> bitCnt_q == 4'h0;
    endproperty
    a_sepClears: assert property (p_sepClears) else $error("Separator did not close the byte.");

    property p_disabledIdle;
        @(posedge clk) disable iff (rst)
        !enSync_q |=> state_q == sdp_pkg::SDP_IDLE;
    endproperty
    a_disabledIdle: assert property (p_disabledIdle) else $error("Disabled port left idle.");

    property p_riseNoEffect;
        @(posedge clk) disable iff (rst)
        (enSync_q && pins.clkLevel && $past(pins.clkLevel) && $rose(pins.dataLevel)) |=> $stable(state_q) && $stable(bitCnt_q);
    endproperty
    a_riseNoEffect: assert property (p_riseNoEffect) else $error("Data rise under high clock acted.");

    property p_loadRead;
        @(posedge clk) disable iff (rst)
        (state_q == sdp_pkg::SDP_RD && pins.clkFall && bitCnt_q == 4'h0 && enSync_q) |=> shift_q == $past(rdData);
    endproperty
    a_loadRead: assert property (p_loadRead) else $error("Read value not loaded on first fall.");

    property p_driveOnFall;
        @(posedge clk) disable iff (rst)
        (dbgDataOe && $changed(dbgDataOut)) |-> $past(pins.clkFall);
    endproperty
    a_driveOnFall: assert property (p_driveOnFall) else $error("Driven bit changed off a falling edge.");

    property p_releaseAtSep;
        @(posedge clk) disable iff (rst)
        (state_q == sdp_pkg::SDP_RD && pins.clkFall && bitCnt_q == sdp_pkg::SDP_SEP_SLOT) |=> !dbgDataOe;
    endproperty
    a_releaseAtSep: assert property (p_releaseAtSep) else $error("Pin still driven in separator slot.");

    property p_rdStep;
        @(posedge clk) disable iff (rst)
        (acc.rdStrobe && acc.addr < sdp_pkg::SDP_RD_TOP) |-> addr_q == acc.addr + 7'h01;
    endproperty
    a_rdStep: assert property (p_rdStep) else $error("Read address did not step by one.");

endmodule

/* tb/sdp_master_model.sv */
/*
 * Behavioural debug pod that masters the serial debug port.
 * Assumes the bench resolves the shared data line and feeds it back.
 */
`timescale 1ns/1ps
module sdp_master_model (
    // Pacing clock.
    input  wire logic clk,
    // Debug pins.
    output logic      dbgClk,
    output logic      dbgData,
    input  wire logic dbgLine
);
    logic drive;
    logic level;
    logic patt;

    // A released line toggles so that a stale value is never read as data.
    always @(negedge clk) patt <= ~patt;
    assign dbgData = drive ? level : patt;

    // Idle with the clock parked high.
    initial begin
        dbgClk = 1'b1;
        drive  = 1'b1;
        level  = 1'b1;
        patt   = 1'b0;
    end

    // slow clock, data moved while low
    task automatic bitSlot(input logic drv, input logic v, output logic seen);
        dbgClk = 1'b0;
        repeat (2) @(negedge clk);
        drive = drv;
        level = v;
        repeat (6) @(negedge clk);
        dbgClk = 1'b1;
        seen = dbgLine;
        repeat (8) @(negedge clk);
    endtask

    task automatic startCond();
        drive = 1'b1;
        level = 1'b1;
        repeat (8) @(negedge clk);
        level = 1'b0;
        repeat (8) @(negedge clk);
    endtask

    // msb first, nine clocks, park high
    task automatic xferByte(input logic rd, input logic [7:0] wv, input logic sep, output logic [7:0] rv);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bitSlot(!rd, wv[i], s);
            rv[i] = s;
        end
        bitSlot(1'b1, sep, s);
    endtask

    task automatic command(input logic [6:0] a, input logic rw);
        logic [7:0] d;
        startCond();
        xferByte(1'b0, {a, rw}, 1'b0, d);
    endtask
endmodule

/* tb/sdp_serial_debug_port_bench.sv */
/*
 * Self-checking bench for the serial debug slave port.
 * Assumes a combinational register file answering from the access address.
 */
`timescale 1ns/1ps
module sdp_serial_debug_port_bench;
    logic              clk;
    logic              rst;
    logic              instrDisable;
    logic              grantEnable;
    logic              busRequestIn;
    logic              dbgClk;
    logic              mData;
    logic              dbgLine;
    logic              dbgDataOut;
    logic              dbgDataOe;
    logic [7:0]        rdData;
    logic [7:0]        rv;
    logic              writing;
    sdp_pkg::sdp_acc_s acc;
    logic              busGrantOut;
    logic [15:0]       notes[$];
    int                fail_count;
    int                checks_done;
    int                seed;

    sdp_serial_debug_port i_dut (
        .clk          (clk),
        .rst          (rst),
        .instrDisable (instrDisable),
        .grantEnable  (grantEnable),
        .busRequestIn (busRequestIn),
        .dbgClkIn     (dbgClk),
        .dbgDataIn    (dbgLine),
        .dbgDataOut   (dbgDataOut),
        .dbgDataOe    (dbgDataOe),
        .rdData       (rdData),
        .acc          (acc),
        .busGrantOut  (busGrantOut)
    );

    sdp_master_model i_master (
        .clk     (clk),
        .dbgClk  (dbgClk),
        .dbgData (mData),
        .dbgLine (dbgLine)
    );

    // The device wins the shared line whenever it drives it.
    assign dbgLine = dbgDataOe ? dbgDataOut : mData;
    assign rdData  = {1'b0, acc.addr} ^ 8'h5A;

    initial clk = 1'b0;
    always #5 clk = ~clk;

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        checks_done++;
        if (seen !== exp) begin
            fail_count++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic finish_test();
        $display("checks %0d mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    // Every strobe must match the oldest note; a strobe with no note is wrong.
    always @(negedge clk) begin
        if (!rst && (acc.wrStrobe || acc.rdStrobe)) begin
            if (notes.size() == 0)
                check({acc.wrStrobe, acc.addr, acc.wrData}, 16'hFFFF);
            else
                check({acc.rdStrobe, acc.addr, acc.wrStrobe ? acc.wrData : 8'h00}, notes.pop_front());
        end
        if (writing && dbgDataOe)
            check({15'h0000, dbgDataOe}, 16'h0000);
    end

    // Grant must rise within a short bound once it is allowed.
    task automatic waitGrant();
        for (int i = 0; i < 20 && busGrantOut !== 1'b1; i++) @(negedge clk);
        check({15'h0000, busGrantOut}, 16'h0001);
        if (busGrantOut !== 1'b1) finish_test();
    endtask

    task automatic doWrite(input logic [6:0] a, input int n);
        logic [6:0] cur;
        logic [7:0] d;
        cur = a;
        writing = 1'b1;
        i_master.command(a, 1'b0);
        for (int k = 0; k < n; k++) begin
            d = 8'($urandom);
            notes.push_back({1'b0, cur, d});
            i_master.xferByte(1'b0, d, k == n - 1, rv);
            if (grantEnable && k < n - 1)
                check({15'h0000, busGrantOut}, 16'h0000);
            if (cur < sdp_pkg::SDP_WR_TOP) cur++;
        end
        writing = 1'b0;
    endtask

    task automatic doRead(input logic [6:0] a, input int n);
        logic [6:0] cur;
        cur = a;
        i_master.command(a, 1'b1);
        for (int k = 0; k < n; k++) begin
            notes.push_back({1'b1, cur, 8'h00});
            i_master.xferByte(1'b1, 8'hFF, k == n - 1, rv);
            check({8'h00, rv}, {8'h00, {1'b0, cur} ^ 8'h5A});
            check({15'h0000, dbgDataOe}, 16'h0000);
            if (cur < sdp_pkg::SDP_RD_TOP) cur++;
        end
    endtask

    // Main sequence, all inputs moved on the falling edge.
    initial begin
        seed = $urandom(3);
        fail_count = 0;
        checks_done = 0;
        writing = 1'b0;
        rst = 1'b1;
        instrDisable = 1'b1;
        grantEnable = 1'b0;
        busRequestIn = 1'b1;
        repeat (20) @(negedge clk);
        rst = 1'b0;
        repeat (6) @(negedge clk);
        check({15'h0000, busGrantOut}, 16'h0000);
        // bytes clocked before any start are ignored
        i_master.xferByte(1'b0, 8'hA5, 1'b1, rv);
        doWrite(7'h00, 1);
        doRead(7'h00, 1);
        doWrite(7'h2E, 4);
        doRead(7'h1E, 4);
        // partial byte ends low, so the restart first raises data under a high clock
        i_master.command(7'h10, 1'b0);
        for (int i = 0; i < 4; i++) i_master.bitSlot(1'b1, ~i[0], rv[0]);
        doWrite(7'h11, 2);
        // pins ignored while the port is disabled
        instrDisable = 1'b0;
        repeat (6) @(negedge clk);
        i_master.command(7'h05, 1'b0);
        i_master.xferByte(1'b0, 8'h77, 1'b1, rv);
        instrDisable = 1'b1;
        repeat (6) @(negedge clk);
        grantEnable = 1'b1;
        waitGrant();
        doWrite(7'h08, 3);
        waitGrant();
        grantEnable = 1'b0;
        for (int i = 0; i < 6; i++) begin
            if ($urandom_range(0, 1) == 1)
                doRead(7'($urandom_range(0, 32)), 2);
            else
                doWrite(7'($urandom_range(0, 48)), 2);
        end
        repeat (20) @(negedge clk);
        check(16'(notes.size()), 16'h0000);
        finish_test();
    end
endmodule
